// ==== src/ias_defs.vh ====
// constants for the interrupt accept sequencer
`ifndef IAS_DEFS_VH
`define IAS_DEFS_VH

`define IAS_NSRC        14
`define IAS_SRC_DT      4'hA

`define IAS_MODE_ACTIVE 3'h0
`define IAS_MODE_SLEEP  3'h1
`define IAS_MODE_STBY   3'h2
`define IAS_MODE_WATCH  3'h3
`define IAS_MODE_SUBACT 3'h4

`define IAS_ST_STACK    4'h4
`define IAS_ST_VECTOR   4'h2
`define IAS_ST_FETCH    4'h4
`define IAS_ST_INTERNAL 4'h4
`define IAS_ST_RETURN   4'h4
`define IAS_WAIT_MAX    4'hD

`define IAS_VEC_BASE    16'h0008
`define IAS_MASK_BIT    7

`define IAS_OFF_REQ     3'h0
`define IAS_OFF_ENA     3'h1
`define IAS_OFF_EDGE    3'h2
`define IAS_OFF_CTRL    3'h3
`define IAS_OFF_STAT    3'h4

`define IAS_CTRL_DT     0
`define IAS_CTRL_LS     1

`endif

// ==== src/ias_interrupt_accept_sequencer.v ====
// interrupt controller and exception entry/return sequencer
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "ias_defs.vh"

// How it works
// - ten internal sources, pending while the global mask bit is one.
// - a request signal from pin or peripheral sets its request flag.
// - highest-priority flagged and enabled source is chosen, others stay pending.
// - chosen request accepted only with mask bit zero, else kept pending.
// - after instruction completes, push next-instruction counter and flags word.
// - exception entry sets the global mask bit to one.
// - vector address formed, its word loaded into counter, execution continues there.
// - no detection at boundary right after flag or/and/xor/load instructions.
// - return instruction pops flags word and counter, resumes at counter.
// - wait for current instruction is 1 to 13 states, block move excluded.
// - entry takes 4 stack, 2 vector, 4 fetch, 4 internal states.
// - per-mode validity: request 0 always, request 1 active/sleep/standby, timer A except standby, direct watch/subactive, others active.
// - invalid source in current mode sets no flag and causes no transition.
// - in sleep, standby or watch, leave low-power mode before exception handling.
// - sleep with direct bit one, low-speed zero: watch, flag on subclock, wake.
// - word accesses, stack included, force address bit zero low.
// - stacked flags word carries the flags byte in both halves.
// - restoring flags takes the even-address byte, odd byte ignored.
// - flags never self-clear; writing zero clears, writing one does nothing.
// - external priority descends from request 0 down to request 5.

module ias_interrupt_accept_sequencer (
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire [31:0] wb_adr_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg         wb_ack_o,
   input  wire [3:0]  extReqPin,
   input  wire [8:0]  periphReq,
   input  wire [2:0]  powerMode,
   input  wire        subclkTick,
   input  wire        instrBoundary,
   input  wire        lastWasFlagsOp,
   input  wire        sleepInstr,
   input  wire        rteStart,
   input  wire [15:0] pcIn,
   input  wire [15:0] spIn,
   input  wire [7:0]  flagsIn,
   input  wire [15:0] memRdData,
   output reg  [15:0] memAddr,
   output reg  [15:0] memWrData,
   output reg         memWe,
   output reg         memRe,
   output reg  [15:0] pcOut,
   output reg         pcLoad,
   output reg  [15:0] spOut,
   output reg         spLoad,
   output reg  [7:0]  flagsOut,
   output reg         flagsLoad,
   output reg         cpuHold,
   output reg         wakeReq,
   output reg         enterWatchReq
);

   // =====================================================
   // states
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_WAKE   = 3'h1;
   localparam [2:0] S_STACK  = 3'h2;
   localparam [2:0] S_VECTOR = 3'h3;
   localparam [2:0] S_FETCH  = 3'h4;
   localparam [2:0] S_INTP   = 3'h5;
   localparam [2:0] S_RETURN = 3'h6;

   // =====================================================
   // functions
   // source order: ext0 ext1 ext4 ext5 keyscan timA..timE direct serial1 serial2 a/d
   function validIn;
      input [3:0] src;
      input [2:0] mode;
      begin
         case (src)
            4'h0:    validIn = (mode <= `IAS_MODE_SUBACT);
            4'h1:    validIn = (mode <= `IAS_MODE_STBY);
            4'h5:    validIn = (mode != `IAS_MODE_STBY);
            4'hA:    validIn = (mode == `IAS_MODE_WATCH) || (mode == `IAS_MODE_SUBACT);
            default: validIn = (mode == `IAS_MODE_ACTIVE);
         endcase
      end
   endfunction

   // lowest index wins; bit 4 flags a hit
   function [4:0] pickHighest;
      input [13:0] cand;
      integer i;
      begin
         pickHighest = 5'h00;
         for (i = `IAS_NSRC - 1; i >= 0; i = i - 1) begin
            if (cand[i]) begin
               pickHighest = {1'b1, i[3:0]};
            end
         end
      end
   endfunction

   function [15:0] wordAddr;
      input [15:0] a;
      begin
         wordAddr = {a[15:1], 1'b0};
      end
   endfunction

   // =====================================================
   // registers
   reg  [3:0]  pinSync1Reg;
   reg  [3:0]  pinSync2Reg;
   reg  [3:0]  pinLastReg;
   reg  [13:0] reqFlagReg;
   reg  [13:0] reqFlagNext;
   reg  [13:0] enableReg;
   reg  [2:0]  edgeSelReg;
   reg  [1:0]  ctrlReg;
   reg         dtArmedReg;
   reg  [2:0]  stateReg;
   reg  [3:0]  cntReg;
   reg  [3:0]  srcReg;
   reg  [3:0]  waitCntReg;
   reg  [3:0]  lastWaitReg;
   reg  [15:0] spWorkReg;

   wire [3:0]  rise;
   wire [3:0]  fall;
   wire [3:0]  pinHit;
   wire [13:0] rawSet;
   wire [13:0] cand;
   wire [4:0]  pick;
   wire        masked;
   wire        wbReq;
   wire        wbWrite;
   wire [2:0]  wbIdx;
   wire [15:0] wbMask;
   wire        dtTick;
   wire        inActive;

   // =====================================================
   // pin synchronisers and edge detection
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         // pins idle high, so no false edge after reset
         pinSync1Reg <= 4'hF;
         pinSync2Reg <= 4'hF;
         pinLastReg  <= 4'hF;
      end else begin
         pinSync1Reg <= extReqPin;
         pinSync2Reg <= pinSync1Reg;
         pinLastReg  <= pinSync2Reg;
      end
   end

   assign rise   = pinSync2Reg & ~pinLastReg;
   assign fall   = ~pinSync2Reg & pinLastReg;
   assign pinHit = {fall[3],
                    edgeSelReg[2] ? rise[2] : fall[2],
                    edgeSelReg[1] ? rise[1] : fall[1],
                    edgeSelReg[0] ? rise[0] : fall[0]};

   assign dtTick = dtArmedReg && subclkTick && (powerMode == `IAS_MODE_WATCH);
   assign rawSet = {periphReq[8:6], dtTick, periphReq[5:0], pinHit};
   assign masked = flagsIn[`IAS_MASK_BIT];
   assign inActive = (powerMode == `IAS_MODE_ACTIVE) || (powerMode == `IAS_MODE_SUBACT);

   // =====================================================
   // request flags and selection
   assign wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbWrite = wbReq && wb_we_i;
   assign wbIdx   = wb_adr_i[4:2];
   assign wbMask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always @* begin : flagUpdate
      integer i;
      i           = 0;
      reqFlagNext = reqFlagReg;
      if (wbWrite && wbIdx == `IAS_OFF_REQ) begin
         reqFlagNext = reqFlagReg & ~(wbMask[13:0] & ~wb_dat_i[13:0]);
      end
      for (i = 0; i < `IAS_NSRC; i = i + 1) begin
         if (rawSet[i] && validIn(i[3:0], powerMode)) begin
            reqFlagNext[i] = 1'b1;
         end
      end
   end

   assign cand = reqFlagReg & enableReg;
   assign pick = pickHighest(cand);

   // =====================================================
   // register file over wishbone
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         reqFlagReg <= 14'h0000;
         enableReg  <= 14'h0000;
         edgeSelReg <= 3'h0;
         ctrlReg    <= 2'h0;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h00000000;
      end else begin
         reqFlagReg <= reqFlagNext;
         wb_ack_o   <= wbReq;
         if (wbWrite) begin
            case (wbIdx)
               `IAS_OFF_ENA:  enableReg  <= (enableReg & ~wbMask[13:0]) | (wb_dat_i[13:0] & wbMask[13:0]);
               `IAS_OFF_EDGE: if (wb_sel_i[0]) edgeSelReg <= wb_dat_i[2:0];
               `IAS_OFF_CTRL: if (wb_sel_i[0]) ctrlReg <= wb_dat_i[1:0];
               default:       ;
            endcase
         end
         if (wbReq && !wb_we_i) begin
            case (wbIdx)
               `IAS_OFF_REQ:  wb_dat_o <= {18'h00000, reqFlagReg};
               `IAS_OFF_ENA:  wb_dat_o <= {18'h00000, enableReg};
               `IAS_OFF_EDGE: wb_dat_o <= {29'h00000000, edgeSelReg};
               `IAS_OFF_CTRL: wb_dat_o <= {30'h00000000, ctrlReg};
               `IAS_OFF_STAT: wb_dat_o <= {16'h0000, lastWaitReg, srcReg, 1'b0, stateReg,
                                           3'h0, dtArmedReg};
               default:       wb_dat_o <= 32'h00000000;
            endcase
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // =====================================================
   // direct transfer arming
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         dtArmedReg    <= 1'b0;
         enterWatchReq <= 1'b0;
      end else begin
         enterWatchReq <= 1'b0;
         if (sleepInstr && ctrlReg[`IAS_CTRL_DT] && !ctrlReg[`IAS_CTRL_LS]) begin
            dtArmedReg    <= 1'b1;
            enterWatchReq <= 1'b1;
         end else if (dtTick) begin
            dtArmedReg <= 1'b0;
         end
      end
   end

   // =====================================================
   // sequencer
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         stateReg    <= S_IDLE;
         cntReg      <= 4'h0;
         srcReg      <= 4'h0;
         waitCntReg  <= 4'h0;
         lastWaitReg <= 4'h0;
         spWorkReg   <= 16'h0000;
         memAddr     <= 16'h0000;
         memWrData   <= 16'h0000;
         memWe       <= 1'b0;
         memRe       <= 1'b0;
         pcOut       <= 16'h0000;
         pcLoad      <= 1'b0;
         spOut       <= 16'h0000;
         spLoad      <= 1'b0;
         flagsOut    <= 8'h00;
         flagsLoad   <= 1'b0;
         cpuHold     <= 1'b0;
         wakeReq     <= 1'b0;
      end else begin
         memWe     <= 1'b0;
         memRe     <= 1'b0;
         pcLoad    <= 1'b0;
         spLoad    <= 1'b0;
         flagsLoad <= 1'b0;
         wakeReq   <= 1'b0;
         case (stateReg)
            S_IDLE: begin
               cpuHold <= 1'b0;
               if (pick[4] && !masked && inActive) begin
                  if (waitCntReg != `IAS_WAIT_MAX) begin
                     waitCntReg <= waitCntReg + 4'h1;
                  end
               end else begin
                  waitCntReg <= 4'h0;
               end
               if (rteStart) begin
                  spWorkReg <= wordAddr(spIn);
                  memAddr   <= wordAddr(spIn);
                  memRe     <= 1'b1;
                  cntReg    <= 4'h0;
                  cpuHold   <= 1'b1;
                  stateReg  <= S_RETURN;
               end else if (pick[4] && !masked && !inActive) begin
                  wakeReq  <= 1'b1;
                  stateReg <= S_WAKE;
               end else if (pick[4] && !masked && instrBoundary && !lastWasFlagsOp) begin
                  srcReg      <= pick[3:0];
                  lastWaitReg <= waitCntReg;
                  spWorkReg   <= wordAddr(spIn) - 16'h0004;
                  memAddr     <= wordAddr(spIn) - 16'h0002;
                  memWrData   <= pcIn;
                  memWe       <= 1'b1;
                  cntReg      <= 4'h1;
                  cpuHold     <= 1'b1;
                  stateReg    <= S_STACK;
               end
            end
            S_WAKE: begin
               if (!pick[4] || masked) begin
                  stateReg <= S_IDLE;
               end else if (inActive) begin
                  stateReg <= S_IDLE;
               end else begin
                  wakeReq <= 1'b1;
               end
            end
            S_STACK: begin
               cntReg <= cntReg + 4'h1;
               if (cntReg == 4'h2) begin
                  memAddr   <= spWorkReg;
                  memWrData <= {flagsIn, flagsIn};
                  memWe     <= 1'b1;
               end
               if (cntReg == `IAS_ST_STACK - 4'h1) begin
                  spOut    <= spWorkReg;
                  spLoad   <= 1'b1;
                  flagsOut <= flagsIn | 8'h80;
                  flagsLoad <= 1'b1;
                  memAddr  <= wordAddr(`IAS_VEC_BASE + {11'h000, srcReg, 1'b0});
                  memRe    <= 1'b1;
                  cntReg   <= 4'h1;
                  stateReg <= S_VECTOR;
               end
            end
            S_VECTOR: begin
               cntReg <= cntReg + 4'h1;
               if (cntReg == `IAS_ST_VECTOR) begin
                  pcOut    <= wordAddr(memRdData);
                  pcLoad   <= 1'b1;
                  cntReg   <= 4'h1;
                  stateReg <= S_FETCH;
               end
            end
            S_FETCH: begin
               cntReg <= cntReg + 4'h1;
               if (cntReg == `IAS_ST_FETCH) begin
                  cntReg   <= 4'h1;
                  stateReg <= S_INTP;
               end
            end
            S_INTP: begin
               cntReg <= cntReg + 4'h1;
               if (cntReg == `IAS_ST_INTERNAL) begin
                  cpuHold  <= 1'b0;
                  stateReg <= S_IDLE;
               end
            end
            S_RETURN: begin
               cntReg <= cntReg + 4'h1;
               if (cntReg == 4'h0) begin
                  memAddr <= spWorkReg + 16'h0002;
                  memRe   <= 1'b1;
               end
               if (cntReg == 4'h1) begin
                  flagsOut  <= memRdData[15:8];
                  flagsLoad <= 1'b1;
               end
               if (cntReg == `IAS_ST_RETURN - 4'h2) begin
                  pcOut  <= wordAddr(memRdData);
                  pcLoad <= 1'b1;
                  spOut  <= spWorkReg + 16'h0004;
                  spLoad <= 1'b1;
               end
               if (cntReg == `IAS_ST_RETURN - 4'h1) begin
                  cpuHold  <= 1'b0;
                  stateReg <= S_IDLE;
               end
            end
            default: stateReg <= S_IDLE;
         endcase
      end
   end

endmodule

// ==== tb/ias_checker_properties.sv ====
// assertion checker for the interrupt accept sequencer
`timescale 1ns/1ps
// =========================
// checker
module ias_checker (
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_ack_o,
   input wire        instrBoundary,
   input wire        lastWasFlagsOp,
   input wire        rteStart,
   input wire [15:0] spIn,
   input wire [7:0]  flagsIn,
   input wire [15:0] memAddr,
   input wire [15:0] memWrData,
   input wire        memWe,
   input wire        memRe,
   input wire [7:0]  flagsOut,
   input wire        flagsLoad,
   input wire        spLoad,
   input wire        cpuHold
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack too long");
   word_align_a: assert property ((memWe || memRe) |-> !memAddr[0])
      else $error("odd word address");
   push_order_a: assert property ($rose(cpuHold) && memWe |=> !memWe ##1
      (memWe && memWrData[15:8] == memWrData[7:0]) ##1 (spLoad && flagsLoad && memRe))
      else $error("entry push order wrong");
   mask_set_a: assert property (flagsLoad && $past(memWe) |-> flagsOut[7])
      else $error("mask not set on entry");
   mask_hold_a: assert property (instrBoundary && flagsIn[7] && !cpuHold |=> !memWe)
      else $error("masked request taken");
   flags_op_a: assert property (instrBoundary && lastWasFlagsOp && !cpuHold |=> !memWe)
      else $error("detection after flags op");
   hold_entry_a: assert property ($rose(memWe) |=> cpuHold [*8])
      else $error("hold dropped during entry");
   rte_pop_a: assert property (rteStart && !cpuHold |=>
      (memRe && memAddr == $past(spIn)) ##1 (memRe && memAddr == $past(spIn, 2) + 16'h2))
      else $error("return pop order wrong");

   entry_c: cover property (spLoad && flagsLoad && memRe);
   return_c: cover property (flagsLoad && !memRe);
   bus_c: cover property (wb_ack_o);
endmodule

bind ias_interrupt_accept_sequencer ias_checker u_chk (
   .ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .instrBoundary, .lastWasFlagsOp,
   .rteStart, .spIn, .flagsIn, .memAddr, .memWrData, .memWe, .memRe, .flagsOut,
   .flagsLoad, .spLoad, .cpuHold
);

// ==== tb/ias_mem_model.sv ====
// memory model for the cpu stack and vector space
`timescale 1ns/1ps
// =========================
// memory
module ias_mem_model (
   input  wire        ref_clk,
   input  wire [15:0] memAddr,
   input  wire [15:0] memWrData,
   input  wire        memWe,
   input  wire        memRe,
   output reg  [15:0] memRdData
);
   reg [15:0] m [0:65535];
   integer    i;
   initial begin
      for (i = 0; i < 65536; i = i + 1) begin
         m[i] = 16'hA000 ^ i[15:0];
      end
      memRdData = 16'h0000;
   end
   // read data stands one cycle, then the bus shows its inverse
   always @(posedge ref_clk) begin
      if (memWe) begin
         m[memAddr] <= memWrData;
      end
      memRdData <= memRe ? m[memAddr] : ~memRdData;
   end
endmodule

// ==== tb/tb.sv ====
// self-checking testbench for the interrupt accept sequencer
`timescale 1ns/1ps
`include "ias_defs.vh"
// =========================
// bench
module tb;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [31:0] wb_adr_i = 32'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0]  wb_sel_i = 4'h3;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic [3:0]  extReqPin = 4'hF;
   logic [8:0]  periphReq = 9'h0;
   logic [2:0]  powerMode = 3'h0;
   logic        subclkTick = 1'b0;
   logic        instrBoundary = 1'b0;
   logic        lastWasFlagsOp = 1'b0;
   logic        sleepInstr = 1'b0;
   logic        rteStart = 1'b0;
   logic [15:0] pcIn = 16'h1234;
   logic [15:0] spIn = 16'hFE00;
   logic [7:0]  flagsIn = 8'h0;
   logic [31:0] wb_dat_o, rd;
   logic [15:0] memRdData, memAddr, memWrData, pcOut, spOut, pcSeen, spSeen;
   logic [7:0]  flagsOut, flSeen;
   logic        wb_ack_o, memWe, memRe, pcLoad, spLoad, flagsLoad, cpuHold;
   logic        wakeReq, enterWatchReq;
   integer      failures = 0;
   integer      cmp_count = 0;
   integer      reqM = 0;
   integer      src;

   ias_interrupt_accept_sequencer uut (
      .ref_clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i,
      .wb_stb_i, .wb_ack_o, .extReqPin, .periphReq, .powerMode, .subclkTick, .instrBoundary,
      .lastWasFlagsOp, .sleepInstr, .rteStart, .pcIn, .spIn, .flagsIn, .memRdData, .memAddr,
      .memWrData, .memWe, .memRe, .pcOut, .pcLoad, .spOut, .spLoad, .flagsOut, .flagsLoad,
      .cpuHold, .wakeReq, .enterWatchReq
   );
   ias_mem_model u_mem (.ref_clk, .memAddr, .memWrData, .memWe, .memRe, .memRdData);

   always #10 ref_clk = ~ref_clk;

   // =========================
   // tasks
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task wb(input [31:0] a, input w, input [31:0] d);
      integer n;
      n = 0;
      @(posedge ref_clk);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge ref_clk);
         n = n + 1;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      if (n >= 20) failures = failures + 1;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task boundary;
      @(posedge ref_clk);
      instrBoundary <= 1'b1;
      @(posedge ref_clk);
      instrBoundary <= 1'b0;
   endtask
   task watch;
      integer n;
      pcSeen = 'x;
      spSeen = 'x;
      flSeen = 'x;
      for (n = 0; n < 20; n = n + 1) begin
         @(posedge ref_clk);
         if (pcLoad === 1'b1) pcSeen = pcOut;
         if (spLoad === 1'b1) spSeen = spOut;
         if (flagsLoad === 1'b1) flSeen = flagsOut;
      end
   endtask
   task probe(input [7:0] f, input op, input string nm);
      flagsIn <= f;
      lastWasFlagsOp <= op;
      boundary;
      repeat (3) @(posedge ref_clk);
      chk(cpuHold, 1'b0, nm);
      lastWasFlagsOp <= 1'b0;
   endtask
   task accept(input integer s);
      pcIn <= $urandom & 16'hFFFE;
      flagsIn <= $urandom & 8'h7F;
      boundary;
      watch;
      chk(pcSeen, 16'hA000 ^ (`IAS_VEC_BASE + 2 * s), "vector");
      chk(flSeen, flagsIn | 8'h80, "mask");
      chk(spSeen, spIn - 16'h4, "sp");
      chk(u_mem.m[spIn - 16'h2], pcIn, "pushed pc");
      chk(u_mem.m[spIn - 16'h4], {flagsIn, flagsIn}, "pushed flags");
      wb(32'h10, 1'b0, 32'h0);
      chk(rd[11:8], s, "source");
      wb(32'h0, 1'b0, 32'h0);
      chk(rd, reqM, "no auto clear");
      reqM = reqM & ~(1 << s);
      wb(32'h0, 1'b1, ~(32'h1 << s));
   endtask

   // =========================
   // tests
   initial begin
      #(20 * 20000);
      failures = failures + 1;
      conclude;
   end
   initial begin
      void'($urandom(32'h8E00));
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (src = 0; src < 8; src = src + 1) begin
         wb(src * 4, 1'b0, 32'h0);
         chk(rd, 32'h0, "reset value");
      end
      rd = $urandom & 32'h3FFF;
      src = rd;
      wb(32'h4, 1'b1, rd);
      wb(32'h4, 1'b0, 32'h0);
      chk(rd, src, "enable");
      wb(32'h4, 1'b1, 32'h3FFF);
      $display("test registers done");
      extReqPin <= 4'h6;
      periphReq <= 9'h1FF;
      @(posedge ref_clk);
      periphReq <= 9'h0;
      repeat (5) @(posedge ref_clk);
      reqM = 32'h3BF9;
      wb(32'h0, 1'b1, 32'h3FFF);
      wb(32'h0, 1'b0, 32'h0);
      chk(rd, reqM, "flags set");
      probe(8'h80, 1'b0, "masked");
      probe(8'h00, 1'b1, "flags op");
      while (reqM != 0) begin
         src = 0;
         while (!reqM[src]) src = src + 1;
         accept(src);
      end
      $display("test priority done");
      u_mem.m[spIn] = 16'h5AC3;
      u_mem.m[spIn + 16'h2] = 16'h2468;
      rteStart <= 1'b1;
      @(posedge ref_clk);
      rteStart <= 1'b0;
      watch;
      chk(flSeen, 8'h5A, "restored flags");
      chk(pcSeen, 16'h2468, "restored pc");
      chk(spSeen, spIn + 16'h4, "restored sp");
      $display("test return done");
      powerMode <= 3'h2;
      periphReq <= 9'h001;
      @(posedge ref_clk);
      periphReq <= 9'h0;
      powerMode <= 3'h1;
      extReqPin <= 4'h4;
      repeat (6) @(posedge ref_clk);
      chk(wakeReq, 1'b1, "wake");
      chk(cpuHold, 1'b0, "asleep");
      wb(32'h0, 1'b0, 32'h0);
      chk(rd, 32'h2, "mode filter");
      powerMode <= 3'h0;
      reqM = 2;
      accept(1);
      $display("test wake done");
      wb(32'hC, 1'b1, 32'h1);
      sleepInstr <= 1'b1;
      @(posedge ref_clk);
      sleepInstr <= 1'b0;
      @(posedge ref_clk);
      chk(enterWatchReq, 1'b1, "watch entry");
      powerMode <= 3'h3;
      subclkTick <= 1'b1;
      @(posedge ref_clk);
      subclkTick <= 1'b0;
      repeat (2) @(posedge ref_clk);
      wb(32'h0, 1'b0, 32'h0);
      chk(rd, 32'h400, "direct flag");
      $display("test direct transfer done");
      conclude;
   end
endmodule
